// ---- design/cos_pkg.sv ----
// Shared constants, types and the duration lookup of the cache operation sequencer.
// Assumes a single processor clock; all counts below except FILL_SYS_CYCLES are in processor cycles.

package cos_pkg;

  // ---------------------------------------------------------------------------
  // Clock and system-clock ratio
  // ---------------------------------------------------------------------------

  // Processor clock rate.
  localparam int unsigned CLK_FREQ_HZ = 25000000;
  // Ratio of processor cycles per system cycle: allowed range and default.
  localparam int unsigned CLOCK_RATIO_MIN = 2;
  localparam int unsigned CLOCK_RATIO_MAX = 8;
  localparam int unsigned CLOCK_RATIO_DEFAULT = 2;
  // System cycles spent issuing a refill before the latency phase.
  localparam int unsigned FILL_SYS_CYCLES = 2;
  // Width of the duration counter.
  localparam int unsigned CNT_W = 5;

  // ---------------------------------------------------------------------------
  // Operation codes
  // ---------------------------------------------------------------------------

  localparam logic [2:0] OP_D_IDX_WB_INV = 3'h0;
  localparam logic [2:0] OP_D_CREATE_DIRTY = 3'h3;
  localparam logic [2:0] OP_HIT_INV = 3'h4;
  localparam logic [2:0] OP_D_HIT_WB_INV = 3'h5;
  localparam logic [2:0] OP_D_HIT_WB = 3'h7;
  localparam logic [2:0] OP_I_IDX_INV = 3'h0;
  localparam logic [2:0] OP_I_FILL = 3'h5;
  localparam logic [2:0] OP_I_HIT_WB = 3'h6;

  // ---------------------------------------------------------------------------
  // Best-case durations
  // ---------------------------------------------------------------------------

  localparam logic [4:0] CYC_IDX_WBI_CLEAN = 5'h0a;
  localparam logic [4:0] CYC_IDX_WBI_DIRTY = 5'h0c;
  localparam logic [4:0] CYC_CDE_HIT = 5'h0a;
  localparam logic [4:0] CYC_CDE_MISS_CLEAN = 5'h0d;
  localparam logic [4:0] CYC_CDE_MISS_DIRTY = 5'h0f;
  localparam logic [4:0] CYC_HINV_MISS = 5'h07;
  localparam logic [4:0] CYC_HINV_HIT = 5'h09;
  localparam logic [4:0] CYC_HWBI_MISS = 5'h07;
  localparam logic [4:0] CYC_HWBI_CLEAN = 5'h0c;
  localparam logic [4:0] CYC_HWBI_DIRTY = 5'h0e;
  localparam logic [4:0] CYC_HWB_MISS = 5'h07;
  localparam logic [4:0] CYC_HWB_CLEAN = 5'h0a;
  localparam logic [4:0] CYC_HWB_DIRTY = 5'h0e;
  localparam logic [4:0] CYC_I_IDX_INV = 5'h07;
  localparam logic [4:0] CYC_FILL_BASE = 5'h0a;
  localparam logic [4:0] CYC_IHWB_MISS = 5'h07;
  localparam logic [4:0] CYC_IHWB_HIT = 5'h14;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_RUN = 3'b010,
    ST_ALIGN = 3'b011,
    ST_REQ = 3'b100,
    ST_DATA = 3'b101
  } cos_state_type;

  // Decoded timing of one operation.
  typedef struct packed {
    logic ok;
    logic wb;
    logic fill;
    logic [4:0] cycles;
  } cos_timing_type;

  // Maps cache, code and hit/dirty outcome to the operation's timing.
  function automatic cos_timing_type cos_timing(input logic icache, input logic [2:0] code,
                                                input logic hit, input logic dirty);
    cos_timing_type t;
    t = '{ok: 1'b1, wb: 1'b0, fill: 1'b0, cycles: CYC_HINV_MISS};
    if (icache) begin
      unique case (code)
        OP_I_IDX_INV: t.cycles = CYC_I_IDX_INV;
        OP_HIT_INV: t.cycles = hit ? CYC_HINV_HIT : CYC_HINV_MISS;
        OP_I_FILL: begin
          t.fill = 1'b1;
          t.cycles = CYC_FILL_BASE;
        end
        OP_I_HIT_WB: begin
          t.wb = hit;
          t.cycles = hit ? CYC_IHWB_HIT : CYC_IHWB_MISS;
        end
        default: t.ok = 1'b0;
      endcase
    end else begin
      unique case (code)
        OP_D_IDX_WB_INV: begin
          t.wb = dirty;
          t.cycles = dirty ? CYC_IDX_WBI_DIRTY : CYC_IDX_WBI_CLEAN;
        end
        OP_D_CREATE_DIRTY: begin
          t.wb = !hit && dirty;
          t.cycles = hit ? CYC_CDE_HIT : (dirty ? CYC_CDE_MISS_DIRTY : CYC_CDE_MISS_CLEAN);
        end
        OP_HIT_INV: t.cycles = hit ? CYC_HINV_HIT : CYC_HINV_MISS;
        OP_D_HIT_WB_INV: begin
          t.wb = hit && dirty;
          t.cycles = !hit ? CYC_HWBI_MISS : (dirty ? CYC_HWBI_DIRTY : CYC_HWBI_CLEAN);
        end
        OP_D_HIT_WB: begin
          t.wb = hit && dirty;
          t.cycles = !hit ? CYC_HWB_MISS : (dirty ? CYC_HWB_DIRTY : CYC_HWB_CLEAN);
        end
        default: t.ok = 1'b0;
      endcase
    end
    return t;
  endfunction

endpackage

// ---- design/cos_cycle_counter.sv ----
// Down counter that times one phase of a cache operation.
// Assumes the loader asserts load_i for one cycle with a non-zero value.

`timescale 1ns/1ps

module cos_cycle_counter #(
  parameter int unsigned WIDTH = cos_pkg::CNT_W
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Control.
  input wire logic load_i,
  input wire logic [WIDTH-1:0] value_i,
  // Status.
  output logic expire_o
);
  import cos_pkg::*;

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  // Next count: reload, or step down toward zero.
  always_comb begin
    next_count = count;
    if (load_i) begin
      next_count = value_i;
    end else if (count != '0) begin
      next_count = count - WIDTH'(1);
    end
  end

  // Count register.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // The last cycle of the phase is the one in which the count reads one.
  assign expire_o = (count == WIDTH'(1));

endmodule

// ---- design/cos_sys_divider.sv ----
// Divider that marks the processor cycle in which a system cycle begins.
// Assumes the system clock is the processor clock divided by CLOCK_RATIO.

`timescale 1ns/1ps

module cos_sys_divider #(
  parameter int unsigned CLOCK_RATIO = cos_pkg::CLOCK_RATIO_DEFAULT
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // System clock edge marker.
  output logic sys_edge_o
);
  import cos_pkg::*;

  logic [2:0] phase;
  logic [2:0] next_phase;

  always_comb begin
    next_phase = phase + 3'h1;
    if (phase == 3'(CLOCK_RATIO - 1)) begin
      next_phase = 3'h0;
    end
  end

  // Phase register.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      phase <= 3'h0;
    end else begin
      phase <= next_phase;
    end
  end

  // A system cycle starts at phase zero.
  assign sys_edge_o = (phase == 3'h0);

endmodule

// ---- design/cos_sequencer.sv ----
// Cache operation sequencer: arbitrates and times cache operations.
// Assumes the pipeline holds op fields stable while op_valid_i is high, the
// miss and buffer logic reports its state each cycle, and the bus interface
// pulses refill_last_i when the last refill doubleword appears.
//
// What this block does
// - Misses, write-backs, external requests precede cache operations.
// - Drain pending write-back buffer before operation begins.
// - Instruction miss at issue is serviced first.
// - Cache operation and data miss never overlap.
// - Accepted external request completes before operation starts.
// - Data operations wait for store, response buffers.
// - Response, store buffers hold pending data-cache writes.
// - Dirty write-back loads buffer; later operations stall.
// - Durations are best-case processor cycle counts.
// - Index writeback-invalidate: 10 clean, 12 dirty.
// - Create-dirty: 10 hit, 13 clean, 15 dirty.
// - Hit-invalidate: 7 miss, 9 hit, both caches.
// - Hit writeback-invalidate: 7 miss, 12 clean, 14 dirty.
// - Hit writeback: 7 miss, 10 clean, 14 dirty.
// - Fill: 10 plus alignment, system and memory terms.
// - Instruction hit writeback: 7 miss, 20 hit.
// - Clock ratio is an integer from 2 to 8.
// - Alignment wait is zero to ratio minus one.

`timescale 1ns/1ps

module cos_sequencer #(
  parameter int unsigned CLOCK_RATIO = cos_pkg::CLOCK_RATIO_DEFAULT
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Operation issue from the pipeline.
  input wire logic op_valid_i,
  input wire logic op_icache_i,
  input wire logic [2:0] op_code_i,
  input wire logic op_hit_i,
  input wire logic op_dirty_i,
  // Competing activity.
  input wire logic icache_miss_i,
  input wire logic dcache_miss_i,
  input wire logic writeback_req_i,
  input wire logic ext_req_i,
  input wire logic ext_busy_i,
  // Buffer state.
  input wire logic wb_buf_pending_i,
  input wire logic store_buf_empty_i,
  input wire logic resp_buf_empty_i,
  // Refill progress from the system bus interface.
  input wire logic refill_last_i,
  // Pipeline answers.
  output logic stall_o,
  output logic done_o,
  output logic op_error_o,
  // Buffer and miss control.
  output logic wb_drain_o,
  output logic wb_load_o,
  output logic dmiss_hold_o,
  // Refill request and system cycle marker.
  output logic fill_req_o,
  output logic sys_edge_o
);
  import cos_pkg::*;

  // ---------------------------------------------------------------------------
  // State and latched operation
  // ---------------------------------------------------------------------------

  cos_state_type state;
  cos_state_type next_state;
  logic op_icache;
  logic [2:0] op_code;
  logic op_hit;
  logic op_dirty;
  logic next_op_icache;
  logic [2:0] next_op_code;
  logic next_op_hit;
  logic next_op_dirty;

  cos_timing_type tim;
  logic blocked;
  logic cnt_load;
  logic [CNT_W-1:0] cnt_value;
  logic cnt_expire;

  // Cycles spent requesting a refill: two system cycles at the clock ratio.
  localparam logic [CNT_W-1:0] REQ_CYCLES = CNT_W'(FILL_SYS_CYCLES * CLOCK_RATIO);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------

  // Phase timer shared by the run and refill request phases.
  cos_cycle_counter #(
    .WIDTH(CNT_W)
  ) u_counter (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .load_i(cnt_load),
    .value_i(cnt_value),
    .expire_o(cnt_expire)
  );

  // System cycle marker derived from the processor clock.
  cos_sys_divider #(
    .CLOCK_RATIO(CLOCK_RATIO)
  ) u_divider (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .sys_edge_o(sys_edge_o)
  );

  assign tim = cos_timing(op_icache, op_code, op_hit, op_dirty);

  // ---------------------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------------------

  always_comb begin
    blocked = icache_miss_i || dcache_miss_i || writeback_req_i || ext_req_i || ext_busy_i;
    blocked = blocked || wb_buf_pending_i;
    if (!op_icache && !(store_buf_empty_i && resp_buf_empty_i)) begin
      blocked = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------

  // Next state, latched fields and one-cycle strobes.
  always_comb begin
    next_state = state;
    next_op_icache = op_icache;
    next_op_code = op_code;
    next_op_hit = op_hit;
    next_op_dirty = op_dirty;
    cnt_load = 1'b0;
    cnt_value = tim.cycles;
    done_o = 1'b0;
    op_error_o = 1'b0;
    wb_load_o = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (op_valid_i) begin
          next_op_icache = op_icache_i;
          next_op_code = op_code_i;
          next_op_hit = op_hit_i;
          next_op_dirty = op_dirty_i;
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!tim.ok) begin
          done_o = 1'b1;
          op_error_o = 1'b1;
          next_state = ST_IDLE;
        end else if (!blocked) begin
          cnt_load = 1'b1;
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cnt_expire) begin
          if (tim.fill) begin
            next_state = ST_ALIGN;
          end else begin
            done_o = 1'b1;
            wb_load_o = tim.wb;
            next_state = ST_IDLE;
          end
        end
      end
      ST_ALIGN: begin
        // wait for system edge
        // The edge cycle is already the first request cycle, so the wait
        // before it is zero to ratio minus one cycles, never a full ratio.
        if (sys_edge_o) begin
          cnt_load = 1'b1;
          cnt_value = REQ_CYCLES - CNT_W'(1);
          next_state = ST_REQ;
        end
      end
      ST_REQ: begin
        if (cnt_expire) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (refill_last_i) begin
          done_o = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State and operation registers.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      op_icache <= 1'b0;
      op_code <= 3'h0;
      op_hit <= 1'b0;
      op_dirty <= 1'b0;
    end else begin
      state <= next_state;
      op_icache <= next_op_icache;
      op_code <= next_op_code;
      op_hit <= next_op_hit;
      op_dirty <= next_op_dirty;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------

  assign stall_o = (op_valid_i && state == ST_IDLE) || (state != ST_IDLE);
  assign dmiss_hold_o = (state == ST_RUN) || (state == ST_ALIGN) ||
                        (state == ST_REQ) || (state == ST_DATA);
  // Ask the write-back buffer to retire its data while an operation waits.
  assign wb_drain_o = (state == ST_WAIT) && wb_buf_pending_i;
  // Refill request stands for the two issuing system cycles, from the edge cycle on.
  assign fill_req_o = (state == ST_REQ) || (state == ST_ALIGN && sys_edge_o);

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------

  // Helper: cycles spent so far in the run phase.
  logic [CNT_W-1:0] run_len;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || state != ST_RUN) begin
      run_len <= '0;
    end else begin
      run_len <= run_len + CNT_W'(1);
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  AST_PRIO_BLOCK: assert property (
    state == ST_WAIT && (icache_miss_i || writeback_req_i || ext_req_i) |=> state != ST_RUN)
    else $error("operation started over pending miss or request");
  AST_WB_DRAIN_FIRST: assert property (
    state == ST_WAIT && wb_buf_pending_i |-> wb_drain_o ##1 state != ST_RUN)
    else $error("operation started before write-back buffer drained");
  AST_IMISS_FIRST: assert property (
    state == ST_IDLE && op_valid_i && icache_miss_i |=> state == ST_WAIT ##1 state != ST_RUN)
    else $error("instruction miss not serviced first");
  AST_DMISS_EXCL: assert property (
    $rose(state == ST_RUN) |-> $past(!dcache_miss_i) && dmiss_hold_o)
    else $error("operation overlaps data miss");
  AST_EXT_COMPLETE: assert property (
    state == ST_WAIT && ext_busy_i |=> state == ST_WAIT || state == ST_IDLE)
    else $error("operation started during external request");
  AST_DBUF_EMPTY: assert property (
    $rose(state == ST_RUN) && !op_icache |-> $past(store_buf_empty_i && resp_buf_empty_i))
    else $error("data operation started with buffers not empty");
  AST_DURATION: assert property (
    state == ST_RUN && done_o |-> run_len + CNT_W'(1) == tim.cycles && stall_o)
    else $error("operation duration differs from table");
  AST_WB_LOAD: assert property (
    wb_load_o |-> done_o && (op_icache ? op_hit : op_dirty) ##1 state == ST_IDLE)
    else $error("write-back buffer loaded without dirty write-back");
  AST_ALIGN_BOUND: assert property (
    $rose(state == ST_ALIGN) |-> ##[0:7] fill_req_o)
    else $error("alignment wait exceeds clock ratio");
  AST_RATIO_RANGE: assert property (
    CLOCK_RATIO >= CLOCK_RATIO_MIN && CLOCK_RATIO <= CLOCK_RATIO_MAX)
    else $error("clock ratio outside 2 to 8");

  COV_CLEAN_OP: cover property (state == ST_RUN && done_o && !tim.wb);
  COV_DIRTY_OP: cover property (wb_load_o);
  COV_FILL_DONE: cover property (state == ST_DATA && refill_last_i);
  COV_BLOCKED: cover property (state == ST_WAIT && wb_buf_pending_i ##1 state == ST_WAIT);

endmodule

// ---- testbench/cos_sysbus_model.sv ----
// Behavioural system bus agent that answers refill requests of the sequencer.
// Assumes fill_req_i stays high for the whole request phase on one clock.

`timescale 1ns/1ps

module cos_sysbus_model #(
  parameter int unsigned CLOCK_RATIO = 2
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Refill request and response timing.
  input wire logic fill_req_i,
  input wire logic [3:0] latency_i,
  input wire logic [3:0] data_len_i,
  // Last doubleword marker.
  output logic refill_last_o
);
  // ---------------------------------------------------------------------------
  // Response timing
  // ---------------------------------------------------------------------------

  logic active;
  logic [7:0] cnt;
  logic [7:0] target;

  // latency plus data span.
  // Latency and the inclusive data span are both whole system cycles.
  assign target = 8'((latency_i + data_len_i) * CLOCK_RATIO);
  assign refill_last_o = active && !fill_req_i && (cnt == target - 8'h01);

  // Counts processor cycles from the end of the request phase.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || refill_last_o) begin
      active <= 1'b0;
      cnt <= 8'h00;
    end else if (fill_req_i) begin
      active <= 1'b1;
      cnt <= 8'h00;
    end else if (active) begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// ---- testbench/cos_sequencer_tb.sv ----
// Self-checking testbench of the cache operation sequencer.
// Assumes the design package is compiled first and the bus model beside it.

`timescale 1ns/1ps

module cos_sequencer_tb;
  import cos_pkg::*;

  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------

  localparam int unsigned RATIO = 3;
  logic clk_sys, rst, op_valid, op_icache, op_hit, op_dirty;
  logic [2:0] op_code;
  logic [7:0] blk;
  logic [3:0] lat, dlen;
  logic refill_last, stall_o, done_o, op_error_o, wb_drain_o, wb_load_o;
  logic dmiss_hold_o, fill_req_o, sys_edge_o;
  int error_cnt = 0;
  int samples_checked = 0;

  // ---------------------------------------------------------------------------
  // Instances
  // ---------------------------------------------------------------------------

  cos_sequencer #(.CLOCK_RATIO(RATIO)) dut_u (
    .clk_sys_i(clk_sys), .rst_i(rst), .op_valid_i(op_valid), .op_icache_i(op_icache),
    .op_code_i(op_code), .op_hit_i(op_hit), .op_dirty_i(op_dirty),
    .icache_miss_i(blk[0]), .dcache_miss_i(blk[1]), .writeback_req_i(blk[2]),
    .ext_req_i(blk[3]), .ext_busy_i(blk[4]), .wb_buf_pending_i(blk[5]),
    .store_buf_empty_i(!blk[6]), .resp_buf_empty_i(!blk[7]), .refill_last_i(refill_last),
    .stall_o(stall_o), .done_o(done_o), .op_error_o(op_error_o), .wb_drain_o(wb_drain_o),
    .wb_load_o(wb_load_o), .dmiss_hold_o(dmiss_hold_o), .fill_req_o(fill_req_o),
    .sys_edge_o(sys_edge_o));

  cos_sysbus_model #(.CLOCK_RATIO(RATIO)) bus_u (
    .clk_sys_i(clk_sys), .rst_i(rst), .fill_req_i(fill_req_o), .latency_i(lat),
    .data_len_i(dlen), .refill_last_o(refill_last));

  // Free-running processor clock, 40 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Compares one value and counts the outcome.
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  // Issues one operation, holds the blockers for hold cycles, returns the done cycle.
  task automatic run_op(input logic ic, input logic [2:0] code, input logic hit,
                        input logic dirty, input int hold, input logic [7:0] bmask,
                        output int n, output int fq, output logic wb, output logic err);
    logic seen;
    seen = 1'b0;
    n = 0;
    fq = 0;
    wb = 1'b0;
    err = 1'b0;
    op_icache = ic;
    op_code = code;
    op_hit = hit;
    op_dirty = dirty;
    op_valid = 1'b1;
    blk = bmask;
    while (!seen && n < 300) begin
      @(negedge clk_sys);
      check("stall_o", 1'b1, stall_o);
      if (n >= 1 && n < hold) begin
        check("dmiss_hold_o", (ic && bmask[5:0] == 6'h00 && n >= 2) ? 1'b1 : 1'b0,
              dmiss_hold_o);
        check("wb_drain_o", bmask[5], wb_drain_o);
      end
      if (fill_req_o === 1'b1) fq++;
      if (done_o === 1'b1) begin
        seen = 1'b1;
        wb = wb_load_o;
        err = op_error_o;
      end
      @(posedge clk_sys);
      #1;
      if (!seen) n++;
      if (n == hold) blk = 8'h00;
    end
  endtask

  // Runs one unblocked operation and checks its duration and side effects.
  task automatic dur(input logic ic, input logic [2:0] code, input logic hit,
                     input logic dirty, input int cyc, input logic xwb, input logic xerr);
    int n;
    int fq;
    logic wb;
    logic err;
    run_op(ic, code, hit, dirty, 0, 8'h00, n, fq, wb, err);
    check("done cycle", xerr ? 1 : 1 + cyc, n);
    check("wb_load_o", xwb, wb);
    check("op_error_o", xerr, err);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------

  // Every code and outcome except the instruction fill and instruction codes 1 and 2, back to back, the request held high between them.
  task automatic test_durations();
    dur(1'b0, 3'h0, 1'b1, 1'b0, 10, 1'b0, 1'b0);
    dur(1'b0, 3'h0, 1'b1, 1'b1, 12, 1'b1, 1'b0);
    dur(1'b0, 3'h3, 1'b1, 1'b1, 10, 1'b0, 1'b0);
    dur(1'b0, 3'h3, 1'b0, 1'b0, 13, 1'b0, 1'b0);
    dur(1'b0, 3'h3, 1'b0, 1'b1, 15, 1'b1, 1'b0);
    dur(1'b0, 3'h4, 1'b0, 1'b1, 7, 1'b0, 1'b0);
    dur(1'b0, 3'h4, 1'b1, 1'b0, 9, 1'b0, 1'b0);
    dur(1'b1, 3'h4, 1'b0, 1'b0, 7, 1'b0, 1'b0);
    dur(1'b1, 3'h4, 1'b1, 1'b0, 9, 1'b0, 1'b0);
    dur(1'b0, 3'h5, 1'b0, 1'b1, 7, 1'b0, 1'b0);
    dur(1'b0, 3'h5, 1'b1, 1'b0, 12, 1'b0, 1'b0);
    dur(1'b0, 3'h5, 1'b1, 1'b1, 14, 1'b1, 1'b0);
    dur(1'b0, 3'h7, 1'b0, 1'b1, 7, 1'b0, 1'b0);
    dur(1'b0, 3'h7, 1'b1, 1'b0, 10, 1'b0, 1'b0);
    dur(1'b0, 3'h7, 1'b1, 1'b1, 14, 1'b1, 1'b0);
    dur(1'b1, 3'h0, 1'b0, 1'b0, 7, 1'b0, 1'b0);
    dur(1'b1, 3'h6, 1'b0, 1'b0, 7, 1'b0, 1'b0);
    dur(1'b1, 3'h6, 1'b1, 1'b0, 20, 1'b1, 1'b0);
    // Codes without timing answer with an error pulse.
    dur(1'b0, 3'h1, 1'b0, 1'b0, 0, 1'b0, 1'b1);
    dur(1'b0, 3'h2, 1'b0, 1'b0, 0, 1'b0, 1'b1);
    dur(1'b0, 3'h6, 1'b0, 1'b0, 0, 1'b0, 1'b1);
    dur(1'b1, 3'h3, 1'b0, 1'b0, 0, 1'b0, 1'b1);
    dur(1'b1, 3'h7, 1'b0, 1'b0, 0, 1'b0, 1'b1);
    op_valid = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  // Each competing activity delays the start until it clears.
  task automatic test_blockers();
    int n;
    int fq;
    logic wb;
    logic err;
    for (int b = 0; b < 8; b++) begin
      run_op(1'b0, 3'h4, 1'b1, 1'b0, 6, 8'(1 << b), n, fq, wb, err);
      check("blocked done cycle", 6 + 9, n);
      op_valid = 1'b0;
      @(posedge clk_sys);
      #1;
    end
    // Data-side buffers do not hold back an instruction cache operation.
    run_op(1'b1, 3'h4, 1'b1, 1'b0, 6, 8'hc0, n, fq, wb, err);
    check("icache done cycle", 1 + 9, n);
    op_valid = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  // Instruction fill against a prompt or a slow memory.
  task automatic test_fill(input logic [3:0] ml, input logic [3:0] dl);
    int n;
    int fq;
    logic wb;
    logic err;
    int lo;
    lat = ml;
    dlen = dl;
    lo = 11 + 2 * RATIO + (ml + dl) * RATIO;
    run_op(1'b1, 3'h5, 1'b0, 1'b0, 0, 8'h00, n, fq, wb, err);
    check("fill_req_o cycles", 2 * RATIO, fq);
    check("fill done in window", 1, (n >= lo && n <= lo + RATIO - 1));
    op_valid = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  // System cycle marker repeats every ratio cycles.
  task automatic test_sys_edge();
    int cnt;
    cnt = 0;
    repeat (4 * RATIO) begin
      @(negedge clk_sys);
      if (sys_edge_o === 1'b1) cnt++;
    end
    check("sys_edge_o count", 4, cnt);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------

  initial begin
    rst = 1'b1;
    op_valid = 1'b0;
    op_icache = 1'b0;
    op_code = 3'h0;
    op_hit = 1'b0;
    op_dirty = 1'b0;
    blk = 8'h00;
    lat = 4'h1;
    dlen = 4'h1;
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    @(negedge clk_sys);
    check("idle stall_o", 1'b0, stall_o);
    check("idle done_o", 1'b0, done_o);
    @(posedge clk_sys);
    #1;
    test_durations();
    test_blockers();
    test_fill(4'h1, 4'h1);
    test_fill(4'h5, 4'h4);
    test_sys_edge();
    summarize();
  end

  // Cuts a hang short well after the expected run length.
  initial begin
    #(20000 * 40);
    error_cnt++;
    summarize();
  end
endmodule
